// ==== rtl/oms_pkg.sv ====
package oms_pkg;

  // ****************************************************************
  // register addresses (7-bit)
  // ****************************************************************
  localparam logic [6:0] OMS_A_PRODUCT_IDENTITY = 7'h00; // fixed identity
  localparam logic [6:0] OMS_A_REVISION_IDENTITY = 7'h01; // revision
  localparam logic [6:0] OMS_A_MOVE = 7'h02; // movement flag
  localparam logic [6:0] OMS_A_DX = 7'h03; // x displacement
  localparam logic [6:0] OMS_A_DY = 7'h04; // y displacement
  localparam logic [6:0] OMS_A_SQUAL = 7'h05; // surface quality
  localparam logic [6:0] OMS_A_EXP_HI = 7'h06; // exposure upper byte
  localparam logic [6:0] OMS_A_EXP_LO = 7'h07; // exposure lower byte
  localparam logic [6:0] OMS_A_PIX_BRT = 7'h08; // brightest pixel
  localparam logic [6:0] OMS_A_PIX_AVG = 7'h09; // average pixel
  localparam logic [6:0] OMS_A_PIX_DRK = 7'h0A; // darkest pixel
  localparam logic [6:0] OMS_A_DUMP = 7'h0B; // frame dump port
  localparam logic [6:0] OMS_A_SCTRL = 7'h0D; // sensor control
  localparam logic [6:0] OMS_A_ACT_IDL1 = 7'h0E; // active to idle1 time
  localparam logic [6:0] OMS_A_IDL1_PER = 7'h0F; // idle1 frame period
  localparam logic [6:0] OMS_A_IDL1_IDL2 = 7'h10; // idle1 to idle2 time
  localparam logic [6:0] OMS_A_IDL2_PER = 7'h11; // idle2 frame period
  localparam logic [6:0] OMS_A_IDL2_IDL3 = 7'h12; // idle2 to idle3 time
  localparam logic [6:0] OMS_A_IDL3_PER = 7'h13; // idle3 frame period
  localparam logic [6:0] OMS_A_UNLOCK = 7'h21; // sensor control unlock
  localparam logic [6:0] OMS_A_FGAP = 7'h35; // frame gap setting
  localparam logic [6:0] OMS_A_SRST = 7'h3A; // soft reset trigger
  localparam logic [6:0] OMS_A_REV_N = 7'h3F; // revision complement
  localparam logic [6:0] OMS_A_ILLUM = 7'h40; // illumination control
  localparam logic [6:0] OMS_A_MPIN = 7'h41; // movement pin config
  localparam logic [6:0] OMS_A_BPTR = 7'h42; // burst start pointer
  localparam logic [6:0] OMS_A_AILLUM = 7'h43; // adaptive illumination
  localparam logic [6:0] OMS_A_IDLE_CFG = 7'h45; // idle mode config
  localparam logic [6:0] OMS_A_BURST = 7'h63; // burst readout port
  localparam logic [6:0] OMS_A_BURST_LAST = 7'h09; // last byte of a burst

  // ****************************************************************
  // reset values, command codes, field positions
  // ****************************************************************
  localparam logic [7:0] OMS_R_ZERO = 8'h00; // zero default
  localparam logic [15:0] OMS_R_EXPOSURE = 16'h0100; // exposure default
  localparam logic [7:0] OMS_R_SCTRL = 8'h01;
  localparam logic [7:0] OMS_R_ACT_IDL1 = 8'h46;
  localparam logic [7:0] OMS_R_IDL1_PER = 8'h00;
  localparam logic [7:0] OMS_R_IDL1_IDL2 = 8'h4F;
  localparam logic [7:0] OMS_R_IDL2_PER = 8'h09;
  localparam logic [7:0] OMS_R_IDL2_IDL3 = 8'h2F;
  localparam logic [7:0] OMS_R_IDL3_PER = 8'h31;
  localparam logic [7:0] OMS_R_FGAP = 8'hF0;
  localparam logic [7:0] OMS_R_MPIN = 8'h40;
  localparam logic [7:0] OMS_R_BPTR = 8'h03;
  localparam logic [7:0] OMS_R_AILLUM = 8'h08;
  localparam logic [7:0] OMS_C_SRST = 8'h5A; // soft reset code
  localparam logic [7:0] OMS_C_PDOWN = 8'h02; // power down code
  localparam int OMS_F_MOVE = 7; // movement flag bit
  localparam int OMS_F_RW = 7; // write bit of the address byte

  // ****************************************************************
  // types
  // ****************************************************************
  typedef enum logic [2:0] {
    OMS_ST_ADDR = 3'b001, // receiving address byte
    OMS_ST_WDATA = 3'b010, // receiving write data
    OMS_ST_RDATA = 3'b100 // shifting read data out
  } oms_state_e;

  // one frame result from the imaging core
  typedef struct packed {
    logic [7:0] dx;
    logic [7:0] dy;
    logic [7:0] squal;
    logic [15:0] exposure;
    logic [7:0] pix_brt;
    logic [7:0] pix_avg;
    logic [7:0] pix_drk;
  } oms_meas_s;

  // software configuration
  typedef struct packed {
    logic [7:0] dump;
    logic [7:0] sctrl;
    logic [7:0] act_idl1;
    logic [7:0] idl1_per;
    logic [7:0] idl1_idl2;
    logic [7:0] idl2_per;
    logic [7:0] idl2_idl3;
    logic [7:0] idl3_per;
    logic [7:0] unlock;
    logic [7:0] fgap;
    logic [7:0] illum;
    logic [7:0] mpin;
    logic [7:0] bptr;
    logic [7:0] aillum;
    logic [7:0] idle_cfg;
  } oms_cfg_s;

  localparam oms_cfg_s OMS_CFG_RST = '{
    dump: OMS_R_ZERO, sctrl: OMS_R_SCTRL, act_idl1: OMS_R_ACT_IDL1,
    idl1_per: OMS_R_IDL1_PER, idl1_idl2: OMS_R_IDL1_IDL2,
    idl2_per: OMS_R_IDL2_PER, idl2_idl3: OMS_R_IDL2_IDL3,
    idl3_per: OMS_R_IDL3_PER, unlock: OMS_R_ZERO, fgap: OMS_R_FGAP,
    illum: OMS_R_ZERO, mpin: OMS_R_MPIN, bptr: OMS_R_BPTR,
    aillum: OMS_R_AILLUM, idle_cfg: OMS_R_ZERO};

endpackage : oms_pkg

// ==== rtl/oms_regs.sv ====
`timescale 1ns/1ps
`default_nettype none

module oms_regs #(
  parameter logic [7:0] PRODUCT_CODE = 8'h5C, // arbitrary value
  parameter logic [7:0] REVISION_CODE = 8'h03 // arbitrary value
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ncs_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  input wire logic sample_valid,
  input wire oms_pkg::oms_meas_s sample,
  output oms_pkg::oms_cfg_s cfg,
  output logic powered_down,
  output logic motion_pending
);
  import oms_pkg::*;

  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic ncs_s1_reg; // first stage, read only by second
  logic ncs_s2_reg; // synchronised chip select
  logic sclk_s1_reg; // first stage
  logic sclk_s2_reg; // synchronised serial clock
  logic sclk_d_reg; // delayed copy for edge finding
  logic mosi_s1_reg; // first stage
  logic mosi_s2_reg; // synchronised data in

  // two flops on each pin; sclk gets a third for edges
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ncs_s1_reg <= 1'b1;
      ncs_s2_reg <= 1'b1;
      sclk_s1_reg <= 1'b1;
      sclk_s2_reg <= 1'b1;
      sclk_d_reg <= 1'b1;
      mosi_s1_reg <= 1'b0;
      mosi_s2_reg <= 1'b0;
    end
    else
    begin
      ncs_s1_reg <= ncs_n;
      ncs_s2_reg <= ncs_s1_reg;
      sclk_s1_reg <= sclk;
      sclk_s2_reg <= sclk_s1_reg;
      sclk_d_reg <= sclk_s2_reg;
      mosi_s1_reg <= mosi;
      mosi_s2_reg <= mosi_s1_reg;
    end
  end

  // ****************************************************************
  // serial framing state
  // ****************************************************************
  oms_state_e state_reg; // framing phase
  oms_state_e state_next;
  logic [6:0] rx_sh_reg; // incoming bits
  logic [2:0] bit_cnt_reg; // bit index in byte
  logic [6:0] addr_reg; // address of a pending write
  logic [7:0] tx_sh_reg; // outgoing byte
  logic burst_reg; // burst readout in progress
  logic [6:0] burst_addr_reg; // next burst byte address
  logic miso_reg; // data out pin

  // ****************************************************************
  // measurement and configuration state
  // ****************************************************************
  logic [7:0] dx_reg; // accumulated x movement
  logic [7:0] dy_reg; // accumulated y movement
  logic move_reg; // movement since last report
  logic [7:0] squal_reg;
  logic [15:0] exposure_reg;
  logic [7:0] pix_brt_reg;
  logic [7:0] pix_avg_reg;
  logic [7:0] pix_drk_reg;
  oms_cfg_s cfg_reg; // software settings
  oms_cfg_s cfg_next;
  logic pd_reg; // power down active

  // ****************************************************************
  // edge and byte decode
  // ****************************************************************
  wire selected = ~ncs_s2_reg; // chip select active
  wire sclk_rise = selected & sclk_s2_reg & ~sclk_d_reg; // sample edge
  wire sclk_fall = selected & ~sclk_s2_reg & sclk_d_reg; // drive edge
  wire [7:0] byte_in = {rx_sh_reg, mosi_s2_reg}; // byte incl. last bit
  wire byte_done = sclk_rise & (bit_cnt_reg == 3'h7); // eighth bit
  wire in_addr = (state_reg == OMS_ST_ADDR);
  wire in_wdata = (state_reg == OMS_ST_WDATA);
  wire in_rdata = (state_reg == OMS_ST_RDATA);
  wire is_write_cmd = byte_in[OMS_F_RW]; // msb high means write
  wire is_burst_cmd = (byte_in[6:0] == OMS_A_BURST);

  // read data is fetched as the address byte ends
  wire load_fire = byte_done & ((in_addr & ~is_write_cmd) | (in_rdata & burst_reg));
  wire load_is_burst = in_addr ? is_burst_cmd : 1'b1;
  wire [6:0] load_addr = in_addr ? (is_burst_cmd ? cfg_reg.bptr[6:0] : byte_in[6:0])
                                 : burst_addr_reg;

  // write effects after the data byte
  wire wr_fire = byte_done & in_wdata;
  wire soft_hit = wr_fire & (addr_reg == OMS_A_SRST) & (byte_in == OMS_C_SRST);
  wire pd_hit = wr_fire & (addr_reg == OMS_A_SCTRL) & (byte_in == OMS_C_PDOWN);
  wire full_rst = rst | soft_hit; // soft reset returns every default

  // reading y ends a motion report; x is read first by convention
  wire rd_clear = load_fire & (load_addr == OMS_A_DY) & ~pd_reg;

  // ****************************************************************
  // read multiplexer
  // ****************************************************************
  // write-only and unmapped addresses read as zero
  function automatic logic [7:0] rd_byte(input logic [6:0] a);
    logic [7:0] d;
    d = OMS_R_ZERO;
    case (a)
      OMS_A_PRODUCT_IDENTITY: d = PRODUCT_CODE; // never changes
      OMS_A_REVISION_IDENTITY: d = REVISION_CODE;
      OMS_A_MOVE: d = {move_reg, 7'h00};
      OMS_A_DX: d = dx_reg;
      OMS_A_DY: d = dy_reg;
      OMS_A_SQUAL: d = squal_reg;
      OMS_A_EXP_HI: d = exposure_reg[15:8];
      OMS_A_EXP_LO: d = exposure_reg[7:0];
      OMS_A_PIX_BRT: d = pix_brt_reg;
      OMS_A_PIX_AVG: d = pix_avg_reg;
      OMS_A_PIX_DRK: d = pix_drk_reg;
      OMS_A_DUMP: d = cfg_reg.dump;
      OMS_A_SCTRL: d = cfg_reg.sctrl;
      OMS_A_ACT_IDL1: d = cfg_reg.act_idl1;
      OMS_A_IDL1_PER: d = cfg_reg.idl1_per;
      OMS_A_IDL1_IDL2: d = cfg_reg.idl1_idl2;
      OMS_A_IDL2_PER: d = cfg_reg.idl2_per;
      OMS_A_IDL2_IDL3: d = cfg_reg.idl2_idl3;
      OMS_A_IDL3_PER: d = cfg_reg.idl3_per;
      OMS_A_FGAP: d = cfg_reg.fgap;
      OMS_A_REV_N: d = ~REVISION_CODE;
      OMS_A_ILLUM: d = cfg_reg.illum;
      OMS_A_MPIN: d = cfg_reg.mpin;
      OMS_A_BPTR: d = cfg_reg.bptr;
      OMS_A_AILLUM: d = cfg_reg.aillum;
      OMS_A_IDLE_CFG: d = cfg_reg.idle_cfg;
      default: d = OMS_R_ZERO;
    endcase
    return d;
  endfunction : rd_byte

  // burst bytes run upward from the pointer and end after average
  logic [7:0] rd_data; // contents of the addressed register
  // a process, not an assign, so a register change re-runs the lookup
  always_comb
  begin
    rd_data = rd_byte(load_addr);
  end
  wire burst_in_range = (load_addr <= OMS_A_BURST_LAST);
  wire [7:0] burst_byte = burst_in_range ? rd_data : OMS_R_ZERO;
  // power down reads carry no valid data; zero is a safe choice
  wire [7:0] load_data = pd_reg ? OMS_R_ZERO
                                : (load_is_burst ? burst_byte : rd_data);
  wire [6:0] burst_addr_inc = load_addr + 7'h01;

  // ****************************************************************
  // framing phase transitions
  // ****************************************************************
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      OMS_ST_ADDR:
        if (byte_done)
          state_next = is_write_cmd ? OMS_ST_WDATA : OMS_ST_RDATA;
      OMS_ST_WDATA:
        if (byte_done)
          state_next = OMS_ST_ADDR;
      OMS_ST_RDATA:
        // a burst keeps streaming until chip select rises
        if (byte_done & ~burst_reg)
          state_next = OMS_ST_ADDR;
      default:
        state_next = OMS_ST_ADDR;
    endcase
  end

  // ****************************************************************
  // serial port registers
  // ****************************************************************
  // chip select high parks the port; this is the only way out of a burst
  always_ff @(posedge clk)
  begin
    if (rst | ncs_s2_reg)
    begin
      state_reg <= OMS_ST_ADDR;
      bit_cnt_reg <= 3'h0;
      burst_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (sclk_rise)
        bit_cnt_reg <= bit_cnt_reg + 3'h1;
      if (byte_done & in_addr)
        burst_reg <= ~is_write_cmd & is_burst_cmd;
    end
  end

  // shift registers and captured address
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rx_sh_reg <= 7'h00;
      addr_reg <= 7'h00;
      burst_addr_reg <= 7'h00;
    end
    else
    begin
      if (sclk_rise)
        rx_sh_reg <= byte_in[6:0];
      if (byte_done & in_addr)
        addr_reg <= byte_in[6:0];
      if (load_fire)
        burst_addr_reg <= burst_addr_inc;
    end
  end

  // read data loads whole, then goes out msb first on falling edges
  always_ff @(posedge clk)
  begin
    if (rst | ncs_s2_reg)
    begin
      tx_sh_reg <= 8'h00;
      miso_reg <= 1'b0;
    end
    else if (load_fire)
      tx_sh_reg <= load_data;
    else if (sclk_fall & in_rdata)
    begin
      miso_reg <= tx_sh_reg[7];
      tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
    end
  end

  // ****************************************************************
  // configuration registers
  // ****************************************************************
  // writes to read-only or unmapped addresses leave everything alone
  always_comb
  begin
    cfg_next = cfg_reg;
    if (wr_fire)
    begin
      case (addr_reg)
        OMS_A_DUMP: cfg_next.dump = byte_in;
        OMS_A_SCTRL: cfg_next.sctrl = byte_in;
        OMS_A_ACT_IDL1: cfg_next.act_idl1 = byte_in;
        OMS_A_IDL1_PER: cfg_next.idl1_per = byte_in;
        OMS_A_IDL1_IDL2: cfg_next.idl1_idl2 = byte_in;
        OMS_A_IDL2_PER: cfg_next.idl2_per = byte_in;
        OMS_A_IDL2_IDL3: cfg_next.idl2_idl3 = byte_in;
        OMS_A_IDL3_PER: cfg_next.idl3_per = byte_in;
        OMS_A_UNLOCK: cfg_next.unlock = byte_in; // write-only
        OMS_A_FGAP: cfg_next.fgap = byte_in;
        OMS_A_ILLUM: cfg_next.illum = byte_in;
        OMS_A_MPIN: cfg_next.mpin = byte_in;
        OMS_A_BPTR: cfg_next.bptr = byte_in;
        OMS_A_AILLUM: cfg_next.aillum = byte_in;
        OMS_A_IDLE_CFG: cfg_next.idle_cfg = byte_in;
        default: cfg_next = cfg_reg;
      endcase
    end
  end

  // defaults include pointer at x and unlock at zero
  always_ff @(posedge clk)
  begin
    if (full_rst)
      cfg_reg <= OMS_CFG_RST;
    else
      cfg_reg <= cfg_next;
  end

  // power down holds until the soft reset code wakes the part
  always_ff @(posedge clk)
  begin
    if (full_rst)
      pd_reg <= 1'b0;
    else if (pd_hit)
      pd_reg <= 1'b1;
  end

  // ****************************************************************
  // measurement registers
  // ****************************************************************
  // deltas accumulate between reports; a new frame in the clearing
  // cycle is kept, so no movement is lost; no saturation, they wrap
  wire [7:0] dx_base = rd_clear ? OMS_R_ZERO : dx_reg;
  wire [7:0] dy_base = rd_clear ? OMS_R_ZERO : dy_reg;
  wire frame_moved = (sample.dx != 8'h00) | (sample.dy != 8'h00);
  wire frame_take = sample_valid & ~pd_reg; // core is idle in power down

  always_ff @(posedge clk)
  begin
    if (full_rst)
    begin
      dx_reg <= OMS_R_ZERO;
      dy_reg <= OMS_R_ZERO;
      move_reg <= 1'b0;
      squal_reg <= OMS_R_ZERO;
      exposure_reg <= OMS_R_EXPOSURE;
      pix_brt_reg <= OMS_R_ZERO;
      pix_avg_reg <= OMS_R_ZERO;
      pix_drk_reg <= OMS_R_ZERO;
    end
    else if (frame_take)
    begin
      dx_reg <= dx_base + sample.dx;
      dy_reg <= dy_base + sample.dy;
      move_reg <= (move_reg & ~rd_clear) | frame_moved; // set wins
      squal_reg <= sample.squal;
      exposure_reg <= sample.exposure;
      pix_brt_reg <= sample.pix_brt;
      pix_avg_reg <= sample.pix_avg;
      pix_drk_reg <= sample.pix_drk;
    end
    else if (rd_clear)
    begin
      dx_reg <= OMS_R_ZERO;
      dy_reg <= OMS_R_ZERO;
      move_reg <= 1'b0;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign miso = miso_reg;
  assign cfg = cfg_reg;
  assign powered_down = pd_reg;
  assign motion_pending = move_reg;

endmodule : oms_regs

`default_nettype wire

// ==== tb/oms_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// serial port master, sclk idles high
// ****
module oms_host_model (
  input wire logic clk,
  output var logic ncs_n,
  output var logic sclk,
  output var logic mosi,
  input wire logic miso
);
  import oms_pkg::*;
  logic [7:0] bq[$]; // burst bytes seen
  initial
  begin
    ncs_n = 1'b1;
    sclk = 1'b1;
    mosi = 1'b0;
  end
  task automatic wt(input int n);
    repeat (n) @(negedge clk);
  endtask : wt
  // msb first; miso taken late in the high half, before the next fall
  task automatic xb(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      sclk = 1'b0;
      mosi = tx[i];
      wt(4);
      sclk = 1'b1;
      wt(3);
      rx[i] = miso;
      wt(1);
    end
  endtask : xb
  // address byte, gap for data fetch, data byte
  task automatic frame(input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    logic [7:0] r;
    ncs_n = 1'b0;
    wt(4);
    xb(a, r);
    wt(8);
    xb(d, q);
    wt(4);
    ncs_n = 1'b1;
    mosi = ~mosi; // released line shows no stale value
    wt(8);
  endtask : frame
  // burst ends only by deselect
  task automatic burst(input int n);
    logic [7:0] r;
    bq.delete();
    ncs_n = 1'b0;
    wt(4);
    xb({1'b0, OMS_A_BURST}, r);
    wt(8);
    repeat (n)
    begin
      xb(8'h00, r);
      bq.push_back(r);
    end
    wt(4);
    ncs_n = 1'b1;
    mosi = ~mosi;
    wt(8);
  endtask : burst
endmodule : oms_host_model
`default_nettype wire

// ==== tb/oms_regs_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
// ****
// port checker
// ****
module oms_regs_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic ncs_n,
  input wire logic sclk,
  input wire logic mosi,
  input wire logic miso,
  input wire logic sample_valid,
  input wire oms_pkg::oms_meas_s sample,
  input wire oms_pkg::oms_cfg_s cfg,
  input wire logic powered_down,
  input wire logic motion_pending
);
  import oms_pkg::*;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // defaults must be in place once reset lets go
  property p_rst_cfg;
    $fell(rst) |-> cfg == OMS_CFG_RST && !powered_down && !motion_pending;
  endproperty
  a_rst_cfg: assert property (p_rst_cfg) else $error("cfg not at defaults");
  // no settings move while the port is deselected
  property p_cfg_idle;
    ncs_n [*6] |-> $stable(cfg);
  endproperty
  a_cfg_idle: assert property (p_cfg_idle) else $error("cfg moved while idle");
  // synchroniser plus output flop fits in five cycles
  property p_miso_idle;
    ncs_n [*5] |-> !miso;
  endproperty
  a_miso_idle: assert property (p_miso_idle) else $error("miso driven while idle");
  property p_pd_miso;
    powered_down |-> !miso;
  endproperty
  a_pd_miso: assert property (p_pd_miso) else $error("read data in power down");
  property p_pd_enter;
    $rose(powered_down) |-> cfg.sctrl == OMS_C_PDOWN;
  endproperty
  a_pd_enter: assert property (p_pd_enter) else $error("power down without code");
  property p_pd_exit;
    $fell(powered_down) |-> cfg == OMS_CFG_RST;
  endproperty
  a_pd_exit: assert property (p_pd_exit) else $error("wake without full reset");
  property p_move_set;
    sample_valid && !powered_down && (sample.dx != 8'h00 || sample.dy != 8'h00)
      |=> motion_pending;
  endproperty
  a_move_set: assert property (p_move_set) else $error("movement not flagged");
  property p_move_cause;
    $rose(motion_pending) |-> $past(sample_valid);
  endproperty
  a_move_cause: assert property (p_move_cause) else $error("flag without sample");
  c_pd: cover property ($rose(powered_down));
  c_wake: cover property ($fell(powered_down));
  c_move: cover property ($rose(motion_pending));
endmodule : oms_regs_asserts
bind oms_regs oms_regs_asserts u_chk (.clk(clk), .rst(rst), .ncs_n(ncs_n), .sclk(sclk),
  .mosi(mosi), .miso(miso), .sample_valid(sample_valid), .sample(sample), .cfg(cfg),
  .powered_down(powered_down), .motion_pending(motion_pending));
`default_nettype wire

// ==== tb/oms_regs_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module oms_regs_bench;
  import oms_pkg::*;
  localparam logic [7:0] ID_CODE = 8'h6B; // arbitrary value
  localparam logic [7:0] REV_CODE = 8'h12; // arbitrary value
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ncs_n, sclk, mosi, miso, pd, mp, mv, ok;
  logic sample_valid = 1'b0;
  oms_meas_s sample = '0;
  oms_meas_s ms = {24'h0, OMS_R_EXPOSURE, 24'h0}; // expected measurements
  oms_cfg_s cfg;
  oms_cfg_s sh = OMS_CFG_RST; // expected settings
  logic [31:0] sd = 32'h9EDD77EC;
  logic [6:0] a;
  logic [7:0] d, q;
  int n_fail = 0;
  int n_tests = 0;
  // writable addresses in settings field order
  logic [6:0] wa [15] = '{OMS_A_DUMP, OMS_A_SCTRL, OMS_A_ACT_IDL1, OMS_A_IDL1_PER,
    OMS_A_IDL1_IDL2, OMS_A_IDL2_PER, OMS_A_IDL2_IDL3, OMS_A_IDL3_PER, OMS_A_UNLOCK,
    OMS_A_FGAP, OMS_A_ILLUM, OMS_A_MPIN, OMS_A_BPTR, OMS_A_AILLUM, OMS_A_IDLE_CFG};
  always #4 clk = ~clk;
  oms_regs #(.PRODUCT_CODE(ID_CODE), .REVISION_CODE(REV_CODE)) u_dut (.clk(clk), .rst(rst),
    .ncs_n(ncs_n), .sclk(sclk), .mosi(mosi), .miso(miso), .sample_valid(sample_valid),
    .sample(sample), .cfg(cfg), .powered_down(pd), .motion_pending(mp));
  oms_host_model u_host (.clk(clk), .ncs_n(ncs_n), .sclk(sclk), .mosi(mosi), .miso(miso));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  // expected read value of one address
  function automatic logic [7:0] ex(input logic [6:0] ad);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < 15; k++)
      if (wa[k] == ad && ad != OMS_A_UNLOCK)
        r = sh[119-8*k -: 8];
    case (ad)
      OMS_A_PRODUCT_IDENTITY: r = ID_CODE;
      OMS_A_REVISION_IDENTITY: r = REV_CODE;
      OMS_A_REV_N: r = ~REV_CODE;
      OMS_A_MOVE: r = {mv, 7'h00};
      OMS_A_DX: r = ms.dx;
      OMS_A_DY: r = ms.dy;
      OMS_A_SQUAL: r = ms.squal;
      OMS_A_EXP_HI: r = ms.exposure[15:8];
      OMS_A_EXP_LO: r = ms.exposure[7:0];
      OMS_A_PIX_BRT: r = ms.pix_brt;
      OMS_A_PIX_AVG: r = ms.pix_avg;
      OMS_A_PIX_DRK: r = ms.pix_drk;
      default: ;
    endcase
    return r;
  endfunction : ex
  task automatic chk(input logic [119:0] got, input logic [119:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : tally_and_finish
  // reading y clears the deltas and the flag
  task automatic clr();
    ms.dx = 8'h00;
    ms.dy = 8'h00;
    mv = 1'b0;
  endtask : clr
  task automatic wr(input logic [6:0] ad, input logic [7:0] dv);
    logic [7:0] r;
    u_host.frame({1'b1, ad}, dv, r);
    for (int k = 0; k < 15; k++)
      if (wa[k] == ad)
        sh[119-8*k -: 8] = dv;
  endtask : wr
  task automatic rc(input logic [6:0] ad);
    logic [7:0] r;
    u_host.frame({1'b0, ad}, 8'h00, r);
    chk(r, ex(ad));
    if (ad == OMS_A_DY)
      clr();
  endtask : rc
  // random frame result, driven at the falling edge
  task automatic smp();
    sd = lfsr(sd);
    @(negedge clk);
    sample = {sd, sd};
    sample_valid = 1'b1;
    @(negedge clk);
    sample_valid = 1'b0;
    ms = {ms.dx + sample.dx, ms.dy + sample.dy, sample[47:0]};
    mv = mv | (sample.dx != 8'h00 || sample.dy != 8'h00);
    chk(mp, mv);
  endtask : smp
  task automatic bst(input int n);
    int p;
    p = int'(sh.bptr);
    u_host.burst(n);
    for (int i = 0; i < n; i++)
      chk(u_host.bq[i], (p + i > OMS_A_BURST_LAST) ? 8'h00 : ex(7'(p + i)));
    if (p <= OMS_A_DY && p + n > OMS_A_DY)
      clr();
  endtask : bst
  initial
  begin
    mv = 1'b0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    chk(cfg, sh);
    for (int i = 0; i < 128; i++)
      if (i != OMS_A_BURST)
        rc(7'(i));
    smp();
    smp();
    rc(OMS_A_EXP_HI);
    rc(OMS_A_EXP_LO);
    rc(OMS_A_PIX_DRK);
    rd_check: begin
      u_host.frame({1'b0, OMS_A_PRODUCT_IDENTITY}, 8'h00, q);
      ok = (q === ID_CODE);
      rc(OMS_A_MOVE);
      rc(OMS_A_DX);
      rc(OMS_A_DY);
      u_host.frame({1'b0, OMS_A_PRODUCT_IDENTITY}, 8'h00, q);
      ok = ok | (q === ID_CODE);
      chk(ok, 1'b1);
    end
    rc(OMS_A_DX);
    smp();
    bst(7);
    wr(OMS_A_MOVE, 8'hFF);
    rc(OMS_A_MOVE);
    repeat (40)
    begin
      sd = lfsr(sd);
      a = sd[8] ? wa[sd[3:0] % 15] : sd[22:16];
      d = sd[31:24];
      if (a == OMS_A_BURST || a == OMS_A_SRST)
        a = OMS_A_DUMP;
      if (a == OMS_A_SCTRL && d == OMS_C_PDOWN)
        d = 8'h03;
      wr(a, d);
      rc(a);
      chk(cfg, sh);
    end
    wr(OMS_A_UNLOCK, 8'hC3);
    chk(cfg.unlock, 8'hC3);
    rc(OMS_A_UNLOCK);
    wr(OMS_A_BPTR, 8'h08);
    smp();
    bst(3);
    wr(OMS_A_SCTRL, OMS_C_PDOWN);
    chk(pd, 1'b1);
    u_host.frame({1'b0, OMS_A_PRODUCT_IDENTITY}, 8'h00, q);
    chk(q, 8'h00);
    wr(OMS_A_SRST, OMS_C_SRST);
    sh = OMS_CFG_RST;
    ms = {24'h0, OMS_R_EXPOSURE, 24'h0};
    clr();
    chk(pd, 1'b0);
    chk(cfg, sh);
    rc(OMS_A_EXP_HI);
    rc(OMS_A_BPTR);
    // hard reset in mid-run must also bring every default back
    wr(OMS_A_ILLUM, 8'h5A);
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    sh = OMS_CFG_RST;
    repeat (4) @(negedge clk);
    chk(cfg, sh);
    rc(OMS_A_ILLUM);
    tally_and_finish();
  end
  // whole run is about 35k cycles
  initial
  begin
    #800000;
    n_fail++;
    tally_and_finish();
  end
endmodule : oms_regs_bench
`default_nettype wire
